// File: core/edac_pkg.sv
/*
 * constants, field positions and state type of the on-chip nonvolatile
 * byte store control block.
 * assumes a single 125 MHz clock and a cpu that reaches the block through
 * a special function register port.
 */
package edac_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned SLOW_HZ     = 32_000;
    localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_HZ;
    localparam int unsigned WRITE_TICKS = 8;
    localparam int unsigned READ_CYCLES = 2;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned DEPTH = 32;
    localparam int unsigned IDX_W = 5;

    // ----------------------------------------------------------------
    // register port offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_IND1 = 8'h02;
    localparam logic [7:0] ADDR_PTR1 = 8'h03;
    localparam logic [7:0] ADDR_BANK = 8'h04;
    localparam logic [7:0] ADDR_IRQ  = 8'h0b;
    localparam logic [7:0] ADDR_IDX  = 8'h1a;
    localparam logic [7:0] ADDR_VAL  = 8'h1b;
    localparam logic [7:0] CTRL_PTR  = 8'h40;
    localparam logic [7:0] CTRL_BANK = 8'h01;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CTL_RD   = 0;
    localparam int unsigned CTL_READ_ALLOW = 1;
    localparam int unsigned CTL_WR   = 2;
    localparam int unsigned CTL_WRITE_ALLOW = 3;
    localparam int unsigned IRQ_GIE  = 0;
    localparam int unsigned IRQ_ENA  = 1;
    localparam int unsigned IRQ_FLG  = 2;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } edac_state_type;

endpackage

// File: core/edac_write_timer.sv
/*
 * write cycle timer: a free-running divider makes a slow tick, and a
 * write lasts a fixed number of ticks, so its length in clocks varies.
 * assumes start and abort are one-cycle pulses from the control logic.
 */
`timescale 1ns/100ps
module edac_write_timer
    import edac_pkg::*;
#(
    parameter int unsigned DIV   = SLOW_DIV,
    parameter int unsigned TICKS = WRITE_TICKS
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic arst_n,
    // control
    input  wire logic start,
    input  wire logic abort,
    // status
    output logic      busy,
    output logic      done
);
    localparam int unsigned DW = $clog2(DIV);
    localparam int unsigned TW = $clog2(TICKS + 1);

    logic [DW-1:0] divCnt_q;
    logic [TW-1:0] tickCnt_q;
    logic          busy_q;
    wire           tick = (divCnt_q == DW'(DIV - 1));

    assign busy = busy_q;
    assign done = busy_q && tick && (tickCnt_q == TW'(TICKS - 1)) && !abort;

    // ----------------------------------------------------------------
    // free-running slow tick, unrelated to start
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) divCnt_q <= '0;
        else divCnt_q <= tick ? '0 : divCnt_q + 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_q    <= 1'b0;
            tickCnt_q <= '0;
        end else if (start) begin
            busy_q    <= 1'b1;
            tickCnt_q <= '0;
        end else if (done || abort) begin
            busy_q    <= 1'b0;
        end else if (busy_q && tick) begin
            tickCnt_q <= tickCnt_q + 1'b1;
        end
    end

    property p_done_busy;
        @(posedge clock) disable iff (!arst_n)
        done |-> busy_q && tick;
    endproperty
    a_done_busy: assert property (p_done_busy)
        else $error("write done without a running timer");

    property p_no_early_done;
        @(posedge clock) disable iff (!arst_n)
        start |=> !done [*2];
    endproperty
    a_no_early_done: assert property (p_no_early_done)
        else $error("write done right after start");

endmodule

// File: core/edac_core.sv
/*
 * nonvolatile byte store control: index, value, bank, pointer and
 * interrupt registers on a special function register port; the control
 * register is reached only through the indirect access register.
 * assumes one sfr access per cycle and a cpu that acknowledges the
 * interrupt vector with a one-cycle pulse.
 */
`timescale 1ns/100ps
module edac_core
    import edac_pkg::*;
#(
    parameter int unsigned DIV   = SLOW_DIV,
    parameter int unsigned TICKS = WRITE_TICKS
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // special function register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic       sfrRead,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    // cpu interrupt side
    input  wire logic       stackFull,
    input  wire logic       irqAck,
    output logic            irqVector,
    // power mode and status
    input  wire logic       sleepReq,
    output logic            busy
);
    edac_state_type   state_q;
    edac_state_type   state_d;
    logic [7:0]       mem_q [DEPTH];
    logic [IDX_W-1:0] cellIndex_q;
    logic [7:0]       cellValue_q;
    logic [7:0]       indirectPointerOne_q;
    logic             bankSelect_q;
    logic             writeAllow_q;
    logic             readAllow_q;
    logic             wrStart_q;
    logic             rdStart_q;
    logic             globalIrqEnable_q;
    logic             writeDoneIrqEnable_q;
    logic             writeDoneFlag_q;
    logic [1:0]       readCnt_q;
    logic [7:0]       sfrRdata_q;
    logic             timerBusy;
    logic             wrDone;

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    wire ctrlSel  = (sfrAddr == ADDR_IND1) && (bankSelect_q == CTRL_BANK[0])
                 && (indirectPointerOne_q == CTRL_PTR);
    wire ctrlWr   = sfrWrite && ctrlSel;
    wire idle     = (state_q == ST_IDLE);
    wire wrLaunch = ctrlWr && sfrWdata[CTL_WR] && writeAllow_q
                 && idle;
    wire rdLaunch = ctrlWr && sfrWdata[CTL_RD] && readAllow_q
                 && idle && !wrLaunch;
    wire inRead   = (state_q == ST_READ);
    wire rdAbort  = inRead && (!readAllow_q || sleepReq);
    wire rdDone   = inRead && !rdAbort
                 && (readCnt_q == 2'(READ_CYCLES - 1));
    wire wrAbort  = (state_q == ST_WRITE) && sleepReq;
    wire [7:0] ctrlByte = {4'h0, writeAllow_q, wrStart_q,
                           readAllow_q, rdStart_q};
    wire [7:0] irqByte  = {5'h00, writeDoneFlag_q, writeDoneIrqEnable_q,
                           globalIrqEnable_q};
    wire [7:0] rdMux =
        (sfrAddr == ADDR_IDX)  ? {3'b000, cellIndex_q} :
        (sfrAddr == ADDR_VAL)  ? cellValue_q :
        (sfrAddr == ADDR_PTR1) ? indirectPointerOne_q :
        (sfrAddr == ADDR_BANK) ? {7'h00, bankSelect_q} :
        (sfrAddr == ADDR_IRQ)  ? irqByte :
        ctrlSel                ? ctrlByte : RST_BYTE;

    assign sfrRdata  = sfrRdata_q;
    assign busy      = !idle;
    assign irqVector = writeDoneFlag_q && writeDoneIrqEnable_q
                    && globalIrqEnable_q && !stackFull;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (wrLaunch) state_d = ST_WRITE;
                else if (rdLaunch) state_d = ST_READ;
            end
            ST_READ: begin
                if (rdDone || rdAbort) state_d = ST_IDLE;
            end
            ST_WRITE: begin
                if (wrDone || wrAbort) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) state_q <= ST_IDLE;
        else state_q <= state_d;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) readCnt_q <= '0;
        else readCnt_q <= inRead ? readCnt_q + 1'b1 : '0;
    end

    edac_write_timer #(
        .DIV   (DIV),
        .TICKS (TICKS)
    ) u_timer (
        .clock  (clock),
        .arst_n (arst_n),
        .start  (wrLaunch),
        .abort  (wrAbort),
        .busy   (timerBusy),
        .done   (wrDone)
    );

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            writeAllow_q <= 1'b0;
            readAllow_q  <= 1'b0;
        end else if (ctrlWr) begin
            writeAllow_q <= sfrWdata[CTL_WRITE_ALLOW];
            readAllow_q  <= sfrWdata[CTL_READ_ALLOW];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) wrStart_q <= 1'b0;
        else if (wrLaunch) wrStart_q <= 1'b1;
        else if (wrDone || wrAbort) wrStart_q <= 1'b0;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) rdStart_q <= 1'b0;
        else if (rdLaunch) rdStart_q <= 1'b1;
        else if (rdDone || rdAbort) rdStart_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // plain registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cellIndex_q          <= '0;
            indirectPointerOne_q <= RST_BYTE;
            bankSelect_q         <= 1'b0;
        end else if (sfrWrite) begin
            if (sfrAddr == ADDR_IDX) cellIndex_q <= sfrWdata[IDX_W-1:0];
            if (sfrAddr == ADDR_PTR1) indirectPointerOne_q <= sfrWdata;
            if (sfrAddr == ADDR_BANK) bankSelect_q <= sfrWdata[0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) cellValue_q <= RST_BYTE;
        else if (rdDone) cellValue_q <= mem_q[cellIndex_q];
        else if (sfrWrite && sfrAddr == ADDR_VAL) cellValue_q <= sfrWdata;
    end

    always_ff @(posedge clock) begin
        if (wrDone) mem_q[cellIndex_q] <= cellValue_q;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) sfrRdata_q <= RST_BYTE;
        else if (sfrRead) sfrRdata_q <= rdMux;
    end

    // ----------------------------------------------------------------
    // interrupt bits
    // ----------------------------------------------------------------
    wire irqWr = sfrWrite && (sfrAddr == ADDR_IRQ);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) writeDoneFlag_q <= 1'b0;
        else if (wrDone) writeDoneFlag_q <= 1'b1;
        else if (irqAck) writeDoneFlag_q <= 1'b0;
        else if (irqWr) writeDoneFlag_q <= sfrWdata[IRQ_FLG];
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            globalIrqEnable_q    <= 1'b0;
            writeDoneIrqEnable_q <= 1'b0;
        end else begin
            if (irqAck) globalIrqEnable_q <= 1'b0;
            else if (irqWr) globalIrqEnable_q <= sfrWdata[IRQ_GIE];
            if (irqWr) writeDoneIrqEnable_q <= sfrWdata[IRQ_ENA];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_wr_needs_allow;
        @(posedge clock) disable iff (!arst_n)
        ctrlWr && idle && !writeAllow_q |=> !wrStart_q && !timerBusy;
    endproperty
    a_wr_needs_allow: assert property (p_wr_needs_allow)
        else $error("write launched without prior write allow");

    property p_rd_needs_allow;
        @(posedge clock) disable iff (!arst_n)
        ctrlWr && idle && !readAllow_q |=> !rdStart_q;
    endproperty
    a_rd_needs_allow: assert property (p_rd_needs_allow)
        else $error("read launched without prior read allow");

    property p_read_len;
        @(posedge clock) disable iff (!arst_n)
        $rose(rdStart_q) && readAllow_q && !sleepReq
            ##1 readAllow_q && !sleepReq
        |=> !rdStart_q;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("read start not cleared after read cycles");

    property p_read_loads;
        @(posedge clock) disable iff (!arst_n)
        rdDone |=> cellValue_q == $past(mem_q[cellIndex_q]) && !rdStart_q;
    endproperty
    a_read_loads: assert property (p_read_loads)
        else $error("value register not loaded by read");

    property p_value_holds;
        @(posedge clock) disable iff (!arst_n)
        !rdDone && !(sfrWrite && sfrAddr == ADDR_VAL)
        |=> $stable(cellValue_q);
    endproperty
    a_value_holds: assert property (p_value_holds)
        else $error("value register changed without an operation");

    property p_write_end;
        @(posedge clock) disable iff (!arst_n)
        wrDone |=> !wrStart_q && writeDoneFlag_q && idle;
    endproperty
    a_write_end: assert property (p_write_end)
        else $error("write end did not clear start or set flag");

    property p_ack_clears;
        @(posedge clock) disable iff (!arst_n)
        irqAck && !wrDone |=> !writeDoneFlag_q && !globalIrqEnable_q;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("servicing left flag or global enable set");

    property p_vector_gate;
        @(posedge clock) disable iff (!arst_n)
        wrDone && writeDoneIrqEnable_q && globalIrqEnable_q && !irqAck
            && !irqWr |=> irqVector || stackFull;
    endproperty
    a_vector_gate: assert property (p_vector_gate)
        else $error("vector missing after write end");

    property p_index_upper;
        @(posedge clock) disable iff (!arst_n)
        sfrRead && sfrAddr == ADDR_IDX |=> sfrRdata[7:IDX_W] == '0;
    endproperty
    a_index_upper: assert property (p_index_upper)
        else $error("upper index bits not read as zero");

    property p_hidden_ctrl;
        @(posedge clock) disable iff (!arst_n)
        sfrWrite && sfrAddr == ADDR_IND1 && !bankSelect_q
        |=> $stable(writeAllow_q) && $stable(readAllow_q);
    endproperty
    a_hidden_ctrl: assert property (p_hidden_ctrl)
        else $error("control register reached from bank 0");

endmodule

// File: tb/eeprom_data_access_control_tb.sv
/*
 * self-checking bench for the nonvolatile byte store control block:
 * a queue-free integer model of store, value and irq registers.
 * assumes edac_pkg is compiled first; shortened write timer DIV=4 TICKS=2.
 */
`timescale 1ns/100ps
module eeprom_data_access_control_tb
    import edac_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic       clock;
    logic       arst_n;
    logic [7:0] sfrAddr;
    logic       sfrWrite;
    logic       sfrRead;
    logic [7:0] sfrWdata;
    logic [7:0] sfrRdata;
    logic       stackFull;
    logic       irqAck;
    logic       irqVector;
    logic       sleepReq;
    logic       busy;
    int         n_fail;
    int         n_compared;
    logic [7:0] rd;
    logic [7:0] memM [DEPTH];
    logic [7:0] valM;
    logic [7:0] irqM;

    edac_core #(.DIV(4), .TICKS(2)) dut (
        .clock(clock), .arst_n(arst_n), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata), .stackFull(stackFull), .irqAck(irqAck),
        .irqVector(irqVector), .sleepReq(sleepReq), .busy(busy)
    );

    initial clock = 1'b0;
    always #4 clock = ~clock;

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // register port accesses
    // ----------------------------------------------------------------
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfrAddr  <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge clock);
        sfrWrite <= 1'b0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clock);
        sfrRead <= 1'b0;
        #1;
        d = sfrRdata;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        logic [7:0] d;
        sfr_rd(a, d);
        check(what, exp, d);
    endtask

    // ----------------------------------------------------------------
    // operations against the model
    // ----------------------------------------------------------------
    task automatic do_write(input logic [4:0] a, input logic [7:0] d);
        int n;
        sfr_wr(ADDR_IDX, {3'b000, a});
        sfr_wr(ADDR_VAL, d);
        sfr_wr(ADDR_IRQ, irqM & 8'hfe);
        sfr_wr(ADDR_IND1, 8'h08);
        sfr_wr(ADDR_IND1, 8'h0c);
        sfr_wr(ADDR_IRQ, irqM);
        sfr_rd(ADDR_IND1, rd);
        check("write start set", 8'h0c, rd);
        n = 0;
        while (rd[CTL_WR] === 1'b1 && n < 50) begin
            sfr_rd(ADDR_IND1, rd);
            n++;
        end
        check("write start cleared", 8'h08, rd);
        memM[a] = d;
        valM = d;
        irqM[IRQ_FLG] = 1'b1;
        rd_chk("done flag", ADDR_IRQ, irqM);
    endtask

    task automatic do_read(input logic [4:0] a);
        int n;
        sfr_wr(ADDR_IDX, {3'b000, a});
        sfr_wr(ADDR_IND1, 8'h02);
        sfr_wr(ADDR_IND1, 8'h03);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (busy === 1'b1 && n < 10);
        check("read length", 8'(READ_CYCLES), 8'(n));
        rd_chk("read start cleared", ADDR_IND1, 8'h02);
        valM = memM[a];
        rd_chk("read value", ADDR_VAL, valM);
    endtask

    task automatic no_busy(input string what);
        repeat (4) begin
            @(posedge clock);
            #1;
            check(what, 8'h00, {7'h00, busy});
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [4:0] a;
        logic [4:0] order [8];
        n_fail = 0;
        n_compared = 0;
        arst_n = 1'b0;
        sfrAddr = 8'h00;
        sfrWrite = 1'b0;
        sfrRead = 1'b0;
        sfrWdata = 8'h00;
        stackFull = 1'b0;
        irqAck = 1'b0;
        sleepReq = 1'b0;
        valM = 8'h00;
        irqM = 8'h00;
        void'($urandom(15919));
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;

        rd_chk("pointer reset", ADDR_PTR1, 8'h00);
        rd_chk("bank reset", ADDR_BANK, 8'h00);
        rd_chk("index reset", ADDR_IDX, 8'h00);
        rd_chk("value reset", ADDR_VAL, 8'h00);
        rd_chk("irq reset", ADDR_IRQ, 8'h00);
        rd_chk("unmapped", 8'h3f, 8'h00);
        sfr_wr(ADDR_PTR1, CTRL_PTR);
        sfr_wr(ADDR_IND1, 8'h0c);
        rd_chk("control hidden", ADDR_IND1, 8'h00);
        sfr_wr(ADDR_BANK, CTRL_BANK);
        rd_chk("control reset", ADDR_IND1, 8'h00);
        sfr_wr(ADDR_IDX, 8'hff);
        rd_chk("index width", ADDR_IDX, 8'h1f);
        $display("test reset done");

        sfr_wr(ADDR_IND1, 8'h0c);
        no_busy("write refused");
        rd_chk("allow only", ADDR_IND1, 8'h08);
        rd_chk("no flag", ADDR_IRQ, 8'h00);
        $display("test refused write done");

        for (int i = 0; i < 8; i++) begin
            order[i] = 5'(i * 4 + ($urandom % 4));
            do_write(order[i], 8'($urandom));
            irqM[IRQ_FLG] = 1'b0;
            sfr_wr(ADDR_IRQ, irqM);
        end
        for (int i = 7; i >= 0; i--) begin
            do_read(order[i]);
        end
        do_read(order[0]);
        $display("test write read done");

        a = order[3];
        sfr_wr(ADDR_IDX, {3'b000, order[5]});
        rd_chk("value held", ADDR_VAL, valM);
        sfr_wr(ADDR_IND1, 8'h00);
        sfr_wr(ADDR_IND1, 8'h01);
        no_busy("read blocked");
        sfr_wr(ADDR_IND1, 8'h03);
        no_busy("read same write");
        rd_chk("read refused", ADDR_IND1, 8'h02);
        rd_chk("value kept", ADDR_VAL, valM);
        $display("test refused read done");

        sfr_wr(ADDR_IND1, 8'h01);
        rd_chk("read cut start", ADDR_IND1, 8'h00);
        rd_chk("read cut value", ADDR_VAL, valM);
        sfr_wr(ADDR_IND1, 8'h02);
        sfr_wr(ADDR_IND1, 8'h03);
        sleepReq <= 1'b1;
        @(posedge clock);
        sleepReq <= 1'b0;
        rd_chk("read slept start", ADDR_IND1, 8'h02);
        rd_chk("read slept value", ADDR_VAL, valM);
        valM = 8'($urandom);
        sfr_wr(ADDR_IDX, {3'b000, order[2]});
        sfr_wr(ADDR_VAL, valM);
        sfr_wr(ADDR_IND1, 8'h08);
        sfr_wr(ADDR_IND1, 8'h0c);
        sleepReq <= 1'b1;
        @(posedge clock);
        sleepReq <= 1'b0;
        rd_chk("write slept start", ADDR_IND1, 8'h08);
        rd_chk("write slept flag", ADDR_IRQ, irqM);
        do_read(order[2]);
        $display("test abort done");

        irqM = 8'h03;
        sfr_wr(ADDR_IRQ, irqM);
        stackFull <= 1'b1;
        do_write(a, 8'($urandom));
        #1;
        check("vector stack full", 8'h00, {7'h00, irqVector});
        @(posedge clock);
        stackFull <= 1'b0;
        #1;
        check("vector raised", 8'h01, {7'h00, irqVector});
        @(posedge clock);
        irqAck <= 1'b1;
        @(posedge clock);
        irqAck <= 1'b0;
        #1;
        check("vector served", 8'h00, {7'h00, irqVector});
        irqM = 8'h02;
        rd_chk("irq after service", ADDR_IRQ, irqM);
        do_write(order[7], 8'($urandom));
        #1;
        check("vector no global", 8'h00, {7'h00, irqVector});
        do_read(a);
        $display("test interrupt done");
        close_out();
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        #(20000 * 8);
        n_fail++;
        close_out();
    end
endmodule
